// [rtl/pcmtm_pkg.sv]
// Constants, codes and types of the upstream PCM tristate memory block
package pcmtm_pkg;
    // Register field positions
    localparam int DIR_BIT = 7;            // Up/down select in address byte
    localparam int RWS_BIT = 7;            // Read/write select in command byte
    localparam int MOC_HI  = 6;
    localparam int MOC_LO  = 3;
    localparam int CODE_W  = 4;            // Tristate code bits per timeslot
    localparam int BYTE_W  = 8;

    // Memory operation codes
    localparam logic [3:0] MOC_WR_B70 = 4'h1;
    localparam logic [3:0] MOC_WR_B74 = 4'h3;
    localparam logic [3:0] MOC_WR_B30 = 4'h2;
    localparam logic [3:0] MOC_WR_B76 = 4'h7;
    localparam logic [3:0] MOC_WR_B54 = 4'h6;
    localparam logic [3:0] MOC_WR_B32 = 4'h5;
    localparam logic [3:0] MOC_WR_B10 = 4'h4;
    localparam logic [3:0] MOC_TRI_ONE = 4'hC;
    localparam logic [3:0] MOC_TRI_ALL = 4'hD;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] CODE_RESET = 4'h0; // All sub-timeslots floating

    // Timing: single access is 9.5 reference cycles, rounded down
    localparam int ACCESS_TENTHS    = 95;
    localparam int TENTHS_PER_CYCLE = 10;
    localparam int ACCESS_CYCLES    = ACCESS_TENTHS / TENTHS_PER_CYCLE;
    localparam int FILL_CYCLES_DEF  = 1035;   // Whole tristate field write

    // Access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01,
        ST_FILL   = 2'b10,
        ST_PUSH   = 2'b11
    } pcmtm_state_t;
endpackage

// [rtl/pcmtm_top.sv]
// Upstream PCM data memory with tristate code field and indirect access
module pcmtm_top #(
    parameter int NPORT       = 4,
    parameter int NSLOT       = 32,
    parameter int FILL_CYCLES = pcmtm_pkg::FILL_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Processor register writes
    input  wire logic             data_wr,
    input  wire logic [7:0]       data_in,
    input  wire logic             addr_wr,
    input  wire logic [7:0]       addr_in,
    input  wire logic             cmd_wr,
    input  wire logic [7:0]       cmd_in,
    // Register contents and status
    output logic      [7:0]       mem_access_data_reg,
    output logic      [7:0]       mem_access_address_reg,
    output logic      [7:0]       mem_access_command_reg,
    output logic                  memory_access_busy_flag,
    // Read result stream
    output logic                  rd_valid,
    output logic      [7:0]       rd_data,
    input  wire logic             rd_ready,
    // PCM transmit side
    input  wire logic             pcm_frame_sync,
    output logic      [NPORT-1:0] pcm_tx_out,
    output logic      [NPORT-1:0] pcm_tx_oe,
    output logic      [NPORT-1:0] tristate_control_output_n
);
    import pcmtm_pkg::*;

    localparam int NLOC   = NPORT * NSLOT;
    localparam int LOC_W  = $clog2(NLOC);
    localparam int PORT_W = (NPORT > 1) ? $clog2(NPORT) : 1;
    localparam int BIT_W  = LOC_W - PORT_W + 3;
    localparam int CNT_W  = $clog2(FILL_CYCLES + 1);
    localparam logic [CNT_W-1:0] ACC_LAST  = CNT_W'(ACCESS_CYCLES - 1);
    localparam logic [CNT_W-1:0] FILL_LAST = CNT_W'(FILL_CYCLES - 1);

    // Refuse shapes the address byte and bit counter cannot serve
    initial begin
        if (NLOC != (1 << LOC_W) || NLOC > 128 || NPORT < 2 ||
            FILL_CYCLES <= NLOC)
            $error("pcmtm_top: unsupported NPORT/NSLOT/FILL_CYCLES");
    end

    // Byte mask of a sub-timeslot data write; zero for other codes
    function automatic logic [7:0] wr_mask(input logic [3:0] memory_operation_code);
        case (memory_operation_code)
            MOC_WR_B70: wr_mask = 8'hFF;
            MOC_WR_B74: wr_mask = 8'hF0;
            MOC_WR_B30: wr_mask = 8'h0F;
            MOC_WR_B76: wr_mask = 8'hC0;
            MOC_WR_B54: wr_mask = 8'h30;
            MOC_WR_B32: wr_mask = 8'h0C;
            MOC_WR_B10: wr_mask = 8'h03;
            default:    wr_mask = 8'h00;
        endcase
    endfunction

    // Storage: upstream data field and tristate code field
    logic [7:0]        data_mem [NLOC];
    logic [CODE_W-1:0] code_mem [NLOC];

    pcmtm_state_t      st;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        push_byte;
    logic [7:0]        spare;
    logic              spare_valid;
    logic              fs_s1, fs_s2, fs_s3;
    logic [BIT_W-1:0]  bit_cnt;

    // Command decode of an incoming command byte
    wire               idle        = (st == ST_IDLE);
    wire [3:0]         in_moc      = cmd_in[MOC_HI:MOC_LO];
    wire               in_read     = cmd_in[RWS_BIT];
    wire               in_rd_data  = in_read && !in_moc[3];
    wire               in_wr_data  = !in_read && (wr_mask(in_moc) != 8'h00);
    wire               in_tri_one  = (in_moc == MOC_TRI_ONE);
    wire               in_tri_all  = (in_moc == MOC_TRI_ALL);
    wire               in_single   = in_rd_data || in_wr_data || in_tri_one;
    wire               take_cmd    = cmd_wr && idle && (in_single || in_tri_all);
    // Upstream-only commands address the upstream block whatever was set
    wire               force_up    = in_wr_data || in_tri_one || in_tri_all;

    // Latched command decode used during the access
    wire [3:0]         memory_operation_code         = mem_access_command_reg[MOC_HI:MOC_LO];
    wire               is_read     = mem_access_command_reg[RWS_BIT];
    wire [7:0]         mask        = is_read ? 8'h00 : wr_mask(memory_operation_code);
    wire [LOC_W-1:0]   loc         = mem_access_address_reg[LOC_W-1:0];
    wire               upstream    = mem_access_address_reg[DIR_BIT];
    wire               op_fire     = (st == ST_ACCESS) && (cnt == ACC_LAST);
    wire               op_tri      = op_fire && (memory_operation_code == MOC_TRI_ONE);
    wire               op_tri_wr   = op_tri && !is_read;
    wire               op_rd       = op_fire && is_read && !memory_operation_code[3];
    wire               op_wr       = op_fire && (mask != 8'h00);
    wire               fill_wr     = (st == ST_FILL) && (cnt < CNT_W'(NLOC));
    wire [LOC_W-1:0]   fill_loc    = cnt[LOC_W-1:0];
    // Downstream is not held here, so a downstream read returns zero
    wire [7:0]         rd_byte     = upstream ? data_mem[loc] : BYTE_RESET;
    wire [7:0]         merged      = (data_mem[loc] & ~mask) |
                                     (mem_access_data_reg & mask);

    // Two-entry read buffer handshake
    wire               push_valid  = (st == ST_PUSH);
    wire               push_ready  = !spare_valid;
    wire               push        = push_valid && push_ready;
    wire               pop         = rd_valid && rd_ready;

    // Sequencer: single access counts out its window, fill its full span
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st  <= ST_IDLE;
            cnt <= '0;
        end else begin
            case (st)
                ST_IDLE: begin
                    cnt <= '0;
                    if (take_cmd)
                        st <= in_tri_all ? ST_FILL : ST_ACCESS;
                end
                ST_ACCESS: begin
                    cnt <= cnt + 1'b1;
                    if (op_fire)
                        st <= op_rd ? ST_PUSH : ST_IDLE;
                end
                ST_FILL: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == FILL_LAST)
                        st <= ST_IDLE;
                end
                ST_PUSH: begin
                    if (push)
                        st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // Busy follows any non-idle state, including the stalled read push
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            memory_access_busy_flag <= 1'b0;
        else
            memory_access_busy_flag <= (take_cmd || !idle) &&
                !(op_fire && !op_rd) && !push &&
                !((st == ST_FILL) && (cnt == FILL_LAST));
    end

    // Address and command registers; writes while busy are dropped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_access_address_reg <= BYTE_RESET;
            mem_access_command_reg <= BYTE_RESET;
        end else begin
            if (addr_wr && idle)
                mem_access_address_reg <= addr_in;
            if (take_cmd) begin
                mem_access_command_reg <= cmd_in;
                if (force_up)
                    mem_access_address_reg[DIR_BIT] <= 1'b1;
            end
        end
    end

    // Data register: processor write, read fetch or code swap
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            mem_access_data_reg <= BYTE_RESET;
        else if (op_rd)
            mem_access_data_reg <= rd_byte;
        else if (op_tri)
            mem_access_data_reg[CODE_W-1:0] <= code_mem[loc];
        else if (data_wr && idle)
            mem_access_data_reg <= data_in;
    end

    // Data field writes, masked to the selected sub-timeslot
    always_ff @(posedge ref_clk) begin
        if (op_wr && upstream)
            data_mem[loc] <= merged;
    end

    // Code field: single swap or whole-field copy of the low data bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NLOC; i++)
                code_mem[i] <= CODE_RESET;
        end else if (fill_wr) begin
            code_mem[fill_loc] <= mem_access_data_reg[CODE_W-1:0];
        end else if (op_tri_wr) begin
            code_mem[loc] <= mem_access_data_reg[CODE_W-1:0];
        end
    end

    // Read buffer: head register plus one spare; a full spare stalls push
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_valid    <= 1'b0;
            rd_data     <= BYTE_RESET;
            spare       <= BYTE_RESET;
            spare_valid <= 1'b0;
        end else if (!rd_valid || (pop && !spare_valid)) begin
            rd_valid <= push;
            if (push)
                rd_data <= push_byte;
        end else if (pop) begin
            rd_data     <= spare;
            spare_valid <= push;
            if (push)
                spare <= push_byte;
        end else if (push) begin
            spare       <= push_byte;
            spare_valid <= 1'b1;
        end
    end

    // Fetched byte is held for the push stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            push_byte <= BYTE_RESET;
        else if (op_rd)
            push_byte <= rd_byte;
    end

    // Frame sync pin passes two flops before the edge detector
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fs_s1 <= 1'b0;
            fs_s2 <= 1'b0;
            fs_s3 <= 1'b0;
        end else begin
            fs_s1 <= pcm_frame_sync;
            fs_s2 <= fs_s1;
            fs_s3 <= fs_s2;
        end
    end

    // Bit position in frame, one PCM bit per reference cycle
    wire fs_pulse = fs_s2 && !fs_s3;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            bit_cnt <= '0;
        else
            bit_cnt <= fs_pulse ? '0 : bit_cnt + 1'b1;
    end

    // Per-port transmit: bits go out MSB first, each pair gated by its code
    wire [2:0] bit_pos = ~bit_cnt[2:0];
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            wire [LOC_W-1:0] tx_loc = {bit_cnt[BIT_W-1:3], PORT_W'(p)};
            wire             tx_en  = code_mem[tx_loc][bit_pos[2:1]];
            wire             tx_bit = data_mem[tx_loc][bit_pos];
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    pcm_tx_out[p]                <= 1'b0;
                    pcm_tx_oe[p]                 <= 1'b0;
                    tristate_control_output_n[p] <= 1'b1;
                end else begin
                    pcm_tx_out[p]                <= tx_en & tx_bit;
                    pcm_tx_oe[p]                 <= tx_en;
                    tristate_control_output_n[p] <= ~tx_en;
                end
            end
        end
    endgenerate

    // Checks
    // Nine busy cycles: the counter runs 0 through ACC_LAST inclusive
    sequence s_busy_window;
        memory_access_busy_flag [*8] ##1 memory_access_busy_flag;
    endsequence
    sequence s_single_end;
        ##1 (st != ST_ACCESS);
    endsequence

    property p_access_len;
        @(posedge ref_clk) disable iff (!nrst)
        (st == ST_ACCESS && cnt == '0) |-> s_busy_window ##0 s_single_end;
    endproperty
    a_access_len: assert property (p_access_len)
        else $error("single access window length wrong");

    property p_start_busy;
        @(posedge ref_clk) disable iff (!nrst)
        take_cmd |=> memory_access_busy_flag;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("busy not raised after command");

    property p_fill_end;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(memory_access_busy_flag) && $past(st) == ST_FILL
            |-> $past(cnt) == FILL_LAST;
    endproperty
    a_fill_end: assert property (p_fill_end)
        else $error("fill ended at wrong count");

    property p_fill_copy;
        @(posedge ref_clk) disable iff (!nrst)
        (st == ST_FILL && cnt == CNT_W'(NLOC - 1)) |=>
            code_mem[NLOC-1] == mem_access_data_reg[CODE_W-1:0];
    endproperty
    a_fill_copy: assert property (p_fill_copy)
        else $error("last code location not filled");

    property p_swap;
        @(posedge ref_clk) disable iff (!nrst)
        op_tri_wr |=> mem_access_data_reg[CODE_W-1:0] == $past(code_mem[loc])
            && code_mem[loc] == $past(mem_access_data_reg[CODE_W-1:0]);
    endproperty
    a_swap: assert property (p_swap)
        else $error("tristate swap wrong");

    property p_dir_force;
        @(posedge ref_clk) disable iff (!nrst)
        take_cmd && force_up |=> mem_access_address_reg[DIR_BIT];
    endproperty
    a_dir_force: assert property (p_dir_force)
        else $error("direction bit not forced");

    property p_low_nibble;
        @(posedge ref_clk) disable iff (!nrst)
        op_wr && upstream && memory_operation_code == MOC_WR_B30 |=>
            data_mem[$past(loc)][7:4] == $past(data_mem[loc][7:4]);
    endproperty
    a_low_nibble: assert property (p_low_nibble)
        else $error("upper bits disturbed by low nibble write");

    property p_read_fetch;
        @(posedge ref_clk) disable iff (!nrst)
        op_rd |=> mem_access_data_reg == $past(rd_byte) ##[1:8] rd_valid;
    endproperty
    a_read_fetch: assert property (p_read_fetch)
        else $error("read fetch wrong");

    property p_drive_pair;
        @(posedge ref_clk) disable iff (!nrst)
        pcm_tx_oe[0] |-> !tristate_control_output_n[0];
    endproperty
    a_drive_pair: assert property (p_drive_pair)
        else $error("driven slot with control high");

    property p_float_pair;
        @(posedge ref_clk) disable iff (!nrst)
        !pcm_tx_oe[0] |-> tristate_control_output_n[0] && !pcm_tx_out[0];
    endproperty
    a_float_pair: assert property (p_float_pair)
        else $error("floating slot not signalled");
endmodule // pcmtm_top

// [testbench/pcmtm_rd_sink.sv]
// Read-result consumer standing on the stream side of the block
module pcmtm_rd_sink (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Stream from the block
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            rd_ready,
    // Bench control
    input  wire logic       stall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    // Ready starts low at time zero and follows stall from the first falling edge, inside reset
    initial begin
        rd_ready = 1'b0;
    end
    // Ready moves at the falling edge, away from the sampling edge
    always @(negedge ref_clk) begin
        rd_ready <= !stall;
    end
    // A word counts as taken only where valid and ready meet
    always @(posedge ref_clk) begin
        if (nrst && rd_valid === 1'b1 && rd_ready) begin
            got.push_back(rd_data);
        end
    end
endmodule // pcmtm_rd_sink

// [testbench/pcmtm_top_tb.sv]
// Self-checking bench of the upstream PCM tristate memory block
module pcmtm_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcmtm_pkg::*;
    localparam int FILL = 133;             // Must exceed the 128 locations
    logic       ref_clk, nrst, data_wr, addr_wr, cmd_wr, rd_valid, rd_ready;
    logic       busy, sync, stall;
    logic [7:0] data_in, addr_in, cmd_in, dreg, areg, creg, rd_data;
    logic [3:0] tx_out, tx_oe, tsc_n;
    logic [7:0] masks[7] = '{8'hFF, 8'hF0, 8'h0F, 8'hC0, 8'h30, 8'h0C, 8'h03};
    logic [3:0] ops[7]   = '{4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4};
    logic       oe_s[256], out_s[256];
    int         n_mismatch, tests_run, n, first, cnt;

    pcmtm_top #(.NPORT(4), .NSLOT(32), .FILL_CYCLES(FILL)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .data_wr(data_wr),
        .data_in(data_in), .addr_wr(addr_wr), .addr_in(addr_in),
        .cmd_wr(cmd_wr), .cmd_in(cmd_in), .mem_access_data_reg(dreg),
        .mem_access_address_reg(areg), .mem_access_command_reg(creg),
        .memory_access_busy_flag(busy), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_ready(rd_ready), .pcm_frame_sync(sync),
        .pcm_tx_out(tx_out), .pcm_tx_oe(tx_oe),
        .tristate_control_output_n(tsc_n));
    pcmtm_rd_sink sink_u (.ref_clk(ref_clk), .nrst(nrst),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
        .stall(stall));

    // Free-running 125 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Compare tasks, one per kind of result
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_mismatch++;
            $display("ERROR %0t count got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One register write: strobe for a single cycle, 0 data 1 addr 2 cmd
    task automatic wr(input int sel, input logic [7:0] v);
        @(negedge ref_clk);
        data_wr <= (sel == 0);
        addr_wr <= (sel == 1);
        cmd_wr  <= (sel == 2);
        data_in <= v;
        addr_in <= v;
        cmd_in  <= v;
        @(negedge ref_clk);
        {data_wr, addr_wr, cmd_wr} <= 3'b000;
    endtask
    // Count busy cycles with a bound, since a stuck flag must not hang
    task automatic wait_idle(output int k);
        k = 0;
        while (busy === 1'b1 && k < 5000) begin
            k++;
            @(negedge ref_clk);
        end
    endtask
    task automatic run(input logic [7:0] c, output int k);
        wr(2, c);
        wait_idle(k);
    endtask
    // Hang guard sized well beyond the expected thousand or so cycles
    initial begin
        #(8 * 30000);
        n_mismatch++;
        test_done();
    end

    initial begin
        {data_wr, addr_wr, cmd_wr, sync, stall} = 5'b00000;
        {data_in, addr_in, cmd_in} = 24'h000000;
        n_mismatch = 0;
        tests_run = 0;
        nrst = 1'b0;
        repeat (8) @(negedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        chk_byte({busy, rd_valid, tx_oe}, 8'h00);
        chk_byte({dreg | areg | creg}, 8'h00);
        chk_byte({4'h0, tsc_n}, 8'h0F);
        // Unsupported code raises no busy
        wr(2, 8'h00);
        @(negedge ref_clk);
        chk_byte({7'h00, busy}, 8'h00);
        // Every data field write code on one slot, seeded to zero first
        for (int i = 0; i < 7; i++) begin
            wr(0, 8'h00); wr(1, 8'hC0); run(8'h08, n);
            wr(0, 8'hFF); run({1'b0, ops[i], 3'b000}, n);
            chk_cnt(n, ACCESS_CYCLES);
            run(8'h80, n);
            chk_byte(dreg, masks[i]);
        end
        // Idle codes in two slots, then a data read through the stream
        wr(0, 8'h3C); wr(1, 8'hC4); run(8'h08, n);
        wr(0, 8'hA5); wr(1, 8'hC0); run(8'h08, n);
        sink_u.got.delete();
        wr(0, 8'h00); run(8'h80, n);
        repeat (3) @(negedge ref_clk);
        chk_byte(dreg, 8'hA5);
        chk_cnt(sink_u.got.size(), 1);
        if (sink_u.got.size() > 0) chk_byte(sink_u.got[0], 8'hA5);
        // Whole field fill to floating; writes during busy are ignored
        wr(0, 8'h00); wr(2, 8'h68);
        wr(0, 8'h77);
        wait_idle(n);
        chk_cnt(n + 2, FILL);
        chk_byte(dreg, 8'h00);
        // Swap with address bit 7 low: old code comes back, bit 7 forced
        wr(0, 8'h09); wr(1, 8'h40); run(8'h60, n);
        chk_cnt(n, ACCESS_CYCLES);
        chk_byte(areg, 8'hC0);
        chk_byte(dreg, 8'h00);
        wr(1, 8'hC0); run(8'hE0, n);
        chk_byte(dreg, 8'h09);
        // One frame on port 0: slot 16 drives bits 7-6 and 1-0 only
        @(negedge ref_clk) sync <= 1'b1;
        repeat (2) @(negedge ref_clk);
        sync <= 1'b0;
        repeat (10) @(negedge ref_clk);
        first = -1;
        cnt = 0;
        for (int i = 0; i < 256; i++) begin
            oe_s[i] = tx_oe[0];
            out_s[i] = tx_out[0];
            cnt += tx_oe[0];
            if (tx_oe[0] === 1'b1 && first < 0) first = i;
            chk_byte({4'h0, tsc_n}, {4'h0, ~tx_oe});
            @(negedge ref_clk);
        end
        chk_cnt(cnt, 4);
        if (first >= 0 && first < 248) begin
            chk_byte({oe_s[first], oe_s[first+1], oe_s[first+2],
                oe_s[first+3], oe_s[first+4], oe_s[first+5],
                oe_s[first+6], oe_s[first+7]}, 8'hC3);
            chk_byte({out_s[first], out_s[first+1], out_s[first+2],
                out_s[first+3], out_s[first+4], out_s[first+5],
                out_s[first+6], out_s[first+7]}, 8'h81);
        end else chk_cnt(first, 0);
        // Fill ignores upper data bits and the address
        wr(0, 8'hF5); wr(1, 8'h00); run(8'h68, n);
        wr(0, 8'h00); wr(1, 8'h93); run(8'hE0, n);
        chk_byte(dreg, 8'h05);
        // Stream buffer: two held results, third read stays busy
        sink_u.got.delete();
        stall = 1'b1;
        wr(1, 8'hC0); run(8'h80, n);
        wr(1, 8'hC4); run(8'h80, n);
        wr(1, 8'hC0); wr(2, 8'h80);
        repeat (20) @(negedge ref_clk);
        chk_byte({7'h00, busy}, 8'h01);
        chk_cnt(sink_u.got.size(), 0);
        stall = 1'b0;
        wait_idle(n);
        repeat (6) @(negedge ref_clk);
        chk_cnt(sink_u.got.size(), 3);
        if (sink_u.got.size() == 3) begin
            chk_byte(sink_u.got[0], 8'hA5);
            chk_byte(sink_u.got[1], 8'h3C);
            chk_byte(sink_u.got[2], 8'hA5);
        end
        test_done();
    end
endmodule // pcmtm_top_tb
